// *** pkg/rtc_update_pkg.sv ***
package rtc_update_pkg;
   // Register word indices; each register sits in one aligned word at byte 4*index
   localparam logic [7:0] idx_seconds     = 8'h10;
   localparam logic [7:0] idx_sec_alarm   = 8'h11;
   localparam logic [7:0] idx_minutes     = 8'h12;
   localparam logic [7:0] idx_min_alarm   = 8'h13;
   localparam logic [7:0] idx_hours       = 8'h14;
   localparam logic [7:0] idx_hrs_alarm   = 8'h15;
   localparam logic [7:0] idx_day_week    = 8'h16;
   localparam logic [7:0] idx_day_month   = 8'h17;
   localparam logic [7:0] idx_month       = 8'h18;
   localparam logic [7:0] idx_year        = 8'h19;
   localparam logic [7:0] idx_ctrl_a      = 8'h1a;
   localparam logic [7:0] idx_ctrl_b      = 8'h1b;
   localparam logic [7:0] idx_status_c    = 8'h1c;
   // Field positions
   localparam int unsigned bit_update_pending = 7;
   localparam int unsigned bit_irq_summary    = 7;
   localparam int unsigned bit_alarm_flag     = 5;
   localparam int unsigned bit_uend_flag      = 4;
   localparam int unsigned bit_hold           = 7;
   localparam int unsigned bit_alarm_en       = 5;
   localparam int unsigned bit_uend_en        = 4;
   localparam int unsigned bit_encoding       = 2;
   localparam int unsigned bit_hour24         = 1;
   // Reset values
   localparam logic [7:0] rst_ctrl_a     = 8'h20;
   localparam logic [7:0] rst_ctrl_b     = 8'h02;
   localparam logic [7:0] rst_seconds    = 8'h00;
   localparam logic [7:0] rst_day_week   = 8'h01;
   localparam logic [7:0] rst_day_month  = 8'h01;
   localparam logic [7:0] rst_month      = 8'h01;
   localparam logic [7:0] rst_year       = 8'h00;
   // Time base: 15-bit divider of the 32.768 kHz link clock
   localparam int unsigned div_width       = 15;
   localparam int unsigned pend_lead_ticks = 8;   // ~244.1 us
   localparam int unsigned cmp_lag_ticks   = 1;   // ~30.5 us
   localparam logic [14:0] div_incr_point  = 15'h7fff;
   localparam logic [14:0] div_pend_point  = 15'h7fff - 15'(pend_lead_ticks);
   // Bus response codes
   localparam logic [1:0] resp_okay   = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;
endpackage

// *** design/rtc_update_core.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - One update per second while hold bit clear and 32k time base is present.
// - Writing hold bit 1 aborts running update and blocks new ones.
// - Update increments seconds, carrying into minutes up through year.
// - All seven counters advance on one tick, rollover in same step.
// - One 32k period after increment, compare alarm and set alarm flag.
// - Alarm matches only when seconds, minutes and hours all equal.
// - Update cycle spans increment to compare; reads meanwhile may be undefined.
// - Pending bit rises eight 32k periods before increment, falls at cycle end.
// - Update-ended flag set on completion of each update cycle.
// - Control B enable bits gate alarm and update-ended onto summary flag.
// - Source flags set on events regardless of enables.
// - Enabling a source whose flag is set raises summary at once.
// - Summary stays high while any source has flag and enable set.
// - Summary flag reads in bit 7 of status register C.
// - Reading status C clears all set flags and the summary flag.
// - Status C double latched; events during read posted after it.
// - With alarm enabled, alarm recurs daily at programmed time.
// - Alarm registers change only by host writes.
// - Register port is the host bus; single-read cost is host's concern.
// - Pending bit is bit 7 of read-only control A at 0x1a.
// - 1 Hz tick derived from 32.768 kHz by a 15-bit divider.
// - Control B bit 2 selects BCD (0) or binary (1) counting.
module rtc_update_core
   import rtc_update_pkg::*;
#(
   parameter int unsigned div_bits = div_width
)
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        clk32k,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq_summary_flag
);

   typedef enum logic [1:0] {
      seq_idle    = 2'b00,
      seq_pending = 2'b01,
      seq_compare = 2'b11
   } seq_state_t;

   // Divider end points; pending leads the increment by a fixed tick count
   localparam logic [div_bits-1:0] div_last_count = '1;
   localparam logic [div_bits-1:0] div_pend_count = div_last_count - div_bits'(pend_lead_ticks);

   // Counter index: 0 sec,1 min,2 hour,3 dow,4 dom,5 month,6 year
   logic [7:0]       time_reg [7];
   logic [7:0]       alarm_reg [3];
   logic [7:0]       ctrl_b_reg;
   logic             alarm_match_flag_reg;
   logic             uend_flag_reg;
   logic             alarm_post_reg;
   logic             uend_post_reg;
   logic             irq_reg;
   seq_state_t       seq_reg;
   logic [div_bits-1:0] div_reg;
   logic [2:0]       sync_reg;
   logic             clk32k_lvl_reg;
   logic             tick32;
   logic             update_pending_flag;
   logic             hold_bit;
   logic             bin_mode;
   logic             inc_now;
   logic             cmp_now;
   logic             stat_read;
   logic [7:0]       time_next [7];

   // Write channel bookkeeping
   logic             aw_held_reg;
   logic             w_held_reg;
   logic [7:0]       waddr_reg;
   logic [31:0]      wdata_reg;
   logic [3:0]       wstrb_reg;
   logic             wr_go;

   assign hold_bit            = ctrl_b_reg[bit_hold];
   assign bin_mode            = ctrl_b_reg[bit_encoding];
   assign update_pending_flag = (seq_reg != seq_idle);

   // Three-stage sampler on the 32k pin; level moves only once stages two and three agree
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync_reg       <= 3'b000;
         clk32k_lvl_reg <= 1'b0;
      end else begin
         sync_reg       <= {sync_reg[1:0], clk32k};
         clk32k_lvl_reg <= (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : clk32k_lvl_reg;
      end
   end
   assign tick32 = sync_reg[1] & sync_reg[2] & ~clk32k_lvl_reg;

   // 15-bit prescaler; parked while hold is set so restart is a full second
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_reg <= '0;
      end else if (hold_bit) begin
         div_reg <= '0;
      end else if (tick32) begin
         div_reg <= div_reg + div_bits'(1);
      end
   end

   assign inc_now = tick32 && !hold_bit && (div_reg == div_last_count);
   assign cmp_now = tick32 && !hold_bit && (seq_reg == seq_compare);

   // Update sequencer: pending, increment, compare
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         seq_reg <= seq_idle;
      end else if (hold_bit) begin
         seq_reg <= seq_idle;
      end else if (tick32) begin
         unique case (seq_reg)
            seq_idle: begin
               if (div_reg == div_pend_count) begin
                  seq_reg <= seq_pending;
               end
            end
            seq_pending: begin
               if (div_reg == div_last_count) begin
                  seq_reg <= seq_compare;
               end
            end
            seq_compare: begin
               seq_reg <= seq_idle;
            end
         endcase
      end
   end

   // Counting helpers for either encoding
   function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
      to_bin = bin ? v : ({4'h0, v[7:4]} * 8'd10) + {4'h0, v[3:0]};
   endfunction
   function automatic logic [7:0] from_bin(input logic [7:0] v, input logic bin);
      from_bin = bin ? v : {4'(v / 8'd10), 4'(v % 8'd10)};
   endfunction
   function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
      if (m == 8'd2) begin
         return (y[1:0] == 2'b00) ? 8'd29 : 8'd28;
      end
      return (m == 8'd4 || m == 8'd6 || m == 8'd9 || m == 8'd11) ? 8'd30 : 8'd31;
   endfunction

   // Cascade of carries, all evaluated for one common step
   always_comb begin
      logic [7:0] s, mi, h, dw, dm, mo, yr, hb;
      logic       pm, h12, c;
      s  = to_bin(time_reg[0], bin_mode);
      mi = to_bin(time_reg[1], bin_mode);
      h12 = !ctrl_b_reg[bit_hour24];
      pm = h12 & time_reg[2][7];
      h  = to_bin({1'b0, time_reg[2][6:0]}, bin_mode);
      dw = time_reg[3];
      dm = to_bin(time_reg[4], bin_mode);
      mo = to_bin(time_reg[5], bin_mode);
      yr = to_bin(time_reg[6], bin_mode);
      c  = 1'b0;
      s  = s + 8'd1;
      if (s >= 8'd60) begin
         s = 8'd0;
         mi = mi + 8'd1;
      end
      if (mi >= 8'd60) begin
         mi = 8'd0;
         if (h12) begin
            if (h == 8'd11) begin
               h = 8'd12;
               c = pm;
               pm = ~pm;
            end else if (h == 8'd12) begin
               h = 8'd1;
            end else begin
               h = h + 8'd1;
            end
         end else begin
            h = h + 8'd1;
            if (h >= 8'd24) begin
               h = 8'd0;
               c = 1'b1;
            end
         end
      end
      if (c) begin
         dw = (dw >= 8'd7) ? 8'd1 : dw + 8'd1;
         if (dm >= month_days(mo, yr)) begin
            dm = 8'd1;
            mo = mo + 8'd1;
         end else begin
            dm = dm + 8'd1;
         end
         if (mo > 8'd12) begin
            mo = 8'd1;
            yr = (yr >= 8'd99) ? 8'd0 : yr + 8'd1;
         end
      end
      hb = from_bin(h, bin_mode);
      time_next[0] = from_bin(s, bin_mode);
      time_next[1] = from_bin(mi, bin_mode);
      time_next[2] = {pm, hb[6:0]};
      time_next[3] = dw;
      time_next[4] = from_bin(dm, bin_mode);
      time_next[5] = from_bin(mo, bin_mode);
      time_next[6] = from_bin(yr, bin_mode);
   end

   // Write path: address and data accepted in either order
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         waddr_reg   <= '0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            waddr_reg   <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_reg <= 1'b0;
         end
      end
   end
   assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

   // Ready outputs come from flops: open while nothing is held
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !(aw_held_reg || (s_axi_awvalid && s_axi_awready)) || wr_go;
         s_axi_wready  <= !(w_held_reg || (s_axi_wvalid && s_axi_wready)) || wr_go;
      end
   end

   // Write response
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= resp_okay;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (waddr_reg[1:0] == 2'b00 && waddr_reg[7:2] >= 6'(idx_seconds)
                          && waddr_reg[7:2] <= 6'(idx_status_c)) ? resp_okay : resp_slverr;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Host writes to control B; hold bit stops the sequencer at once
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_b_reg <= rst_ctrl_b;
      end else if (wr_go && wstrb_reg[0] && waddr_reg[7:2] == 6'(idx_ctrl_b)) begin
         ctrl_b_reg <= {wdata_reg[7:4], 1'b0, wdata_reg[2:1], 1'b0};
      end
   end

   // Alarm bytes: only the host changes them
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         alarm_reg <= '{default: 8'h00};
      end else if (wr_go && wstrb_reg[0]) begin
         if (waddr_reg[7:2] == 6'(idx_sec_alarm)) alarm_reg[0] <= wdata_reg[7:0];
         if (waddr_reg[7:2] == 6'(idx_min_alarm)) alarm_reg[1] <= wdata_reg[7:0];
         if (waddr_reg[7:2] == 6'(idx_hrs_alarm)) alarm_reg[2] <= wdata_reg[7:0];
      end
   end

   // Time counters: host write wins over the increment of the same byte
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_time
         localparam logic [7:0] my_idx = (gi == 0) ? idx_seconds : (gi == 1) ? idx_minutes :
                                         (gi == 2) ? idx_hours : 8'(idx_day_week + 8'(gi - 3));
         localparam logic [7:0] my_rst = (gi == 3) ? rst_day_week : (gi == 4) ? rst_day_month :
                                         (gi == 5) ? rst_month : rst_seconds;
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               time_reg[gi] <= my_rst;
            end else if (wr_go && wstrb_reg[0] && waddr_reg[7:2] == 6'(my_idx)) begin
               time_reg[gi] <= wdata_reg[7:0];
            end else if (inc_now) begin
               time_reg[gi] <= time_next[gi];
            end
         end
      end
   endgenerate

   // A status C read is the accepted read handshake on its address
   assign stat_read = s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:2] == 6'(idx_status_c));

   // Source flags with double latching: events during a read are posted after
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         alarm_match_flag_reg <= 1'b0;
         uend_flag_reg        <= 1'b0;
         alarm_post_reg       <= 1'b0;
         uend_post_reg        <= 1'b0;
      end else begin
         alarm_post_reg <= stat_read && cmp_now && alarm_reg[0] == time_reg[0]
                           && alarm_reg[1] == time_reg[1] && alarm_reg[2] == time_reg[2];
         uend_post_reg  <= stat_read && cmp_now;
         if (stat_read) begin
            alarm_match_flag_reg <= 1'b0;
            uend_flag_reg        <= 1'b0;
         end else begin
            if ((cmp_now && alarm_reg[0] == time_reg[0] && alarm_reg[1] == time_reg[1]
                 && alarm_reg[2] == time_reg[2]) || alarm_post_reg) begin
               alarm_match_flag_reg <= 1'b1;
            end
            if (cmp_now || uend_post_reg) begin
               uend_flag_reg <= 1'b1;
            end
         end
      end
   end

   // Summary flag tracks enabled sources; a read clears it with the flags
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else if (stat_read) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= (alarm_match_flag_reg & ctrl_b_reg[bit_alarm_en])
                  | (uend_flag_reg & ctrl_b_reg[bit_uend_en]);
      end
   end
   assign irq_summary_flag = irq_reg;

   // Read path: one word per read, answer the cycle after the address is taken
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= resp_okay;
      end else begin
         s_axi_arready <= !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= resp_okay;
            s_axi_rdata   <= '0;
            unique case (s_axi_araddr[7:2])
               6'(idx_seconds):   s_axi_rdata[7:0] <= time_reg[0];
               6'(idx_minutes):   s_axi_rdata[7:0] <= time_reg[1];
               6'(idx_hours):     s_axi_rdata[7:0] <= time_reg[2];
               6'(idx_day_week):  s_axi_rdata[7:0] <= time_reg[3];
               6'(idx_day_month): s_axi_rdata[7:0] <= time_reg[4];
               6'(idx_month):     s_axi_rdata[7:0] <= time_reg[5];
               6'(idx_year):      s_axi_rdata[7:0] <= time_reg[6];
               6'(idx_sec_alarm): s_axi_rdata[7:0] <= alarm_reg[0];
               6'(idx_min_alarm): s_axi_rdata[7:0] <= alarm_reg[1];
               6'(idx_hrs_alarm): s_axi_rdata[7:0] <= alarm_reg[2];
               6'(idx_ctrl_a):    s_axi_rdata[7:0] <= {update_pending_flag, rst_ctrl_a[6:0]};
               6'(idx_ctrl_b):    s_axi_rdata[7:0] <= ctrl_b_reg;
               6'(idx_status_c):  s_axi_rdata[7:0] <= {irq_reg, 1'b0, alarm_match_flag_reg,
                                                      uend_flag_reg, 4'h0};
               default:           s_axi_rresp <= resp_slverr;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// *** verification/rtc_update_monitor.sv ***
`timescale 1ns/10ps
// Watches the register port and the summary flag of the update core
module rtc_update_monitor
   import rtc_update_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        irq_summary_flag
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // Word index outside the map
   function automatic logic unmapped(input logic [7:0] a);
      return (a[7:2] < idx_seconds[5:0]) || (a[7:2] > idx_status_c[5:0]);
   endfunction

   // Address and data taken together, as the host offers them
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_write_refused: assert property (wr_taken ##0 unmapped(s_axi_awaddr) |-> ##[1:2]
      (s_axi_bvalid && s_axi_bresp == resp_slverr)) else $error("unmapped write not refused");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data late");
   a_read_refused: assert property (rd_taken ##0 unmapped(s_axi_araddr) |=> s_axi_rresp == resp_slverr)
      else $error("unmapped read not refused");
   a_read_okay: assert property (rd_taken ##0 !unmapped(s_axi_araddr) |=> s_axi_rresp == resp_okay)
      else $error("mapped read refused");
   a_flags_clear: assert property (rd_taken ##0 (s_axi_araddr[7:2] == idx_status_c[5:0])
      |=> !irq_summary_flag) else $error("summary flag survived status read");
   a_write_blocked: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
      else $error("write ready stayed open after a take");
   a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
endmodule

// *** verification/host_model.sv ***
`timescale 1ns/10ps
// Host on the register port; one write and one read at most in flight
module host_model (
   input  wire logic        core_clk,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready,
   output logic             hung
);
   // Idle bus at time zero
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
      s_axi_wstrb = 4'h1;
   end

   // Register write by word index; payload inverted once taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] val, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge core_clk);
      s_axi_awaddr <= {idx[5:0], 2'b00};
      s_axi_wdata <= {24'h0, val};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~s_axi_wdata;
         end
      end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      hung <= (n >= 200);
   endtask

   // Register read by word index
   task automatic rd(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge core_clk);
      s_axi_araddr <= {idx[5:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~s_axi_araddr;
         end
      end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
      data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      hung <= (n >= 200);
   endtask
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   import rtc_update_pkg::*;
   logic        core_clk = 1'b0, rst = 1'b1, clk32k = 1'b0;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_summary_flag;
   int          mismatches = 0, num_checks = 0, cyc = 0, t_hi, i, n;
   // Last second of a year, BCD, and the reset time it rolls over to
   logic [7:0]  set_idx [7] = '{idx_seconds, idx_minutes, idx_hours, idx_day_week,
                                idx_day_month, idx_month, idx_year};
   logic [7:0]  set_val [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
   logic [7:0]  exp_val [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};

   always #2.5 core_clk = ~core_clk;
   // Time base, phase unrelated to the core clock
   initial begin
      #17;
      forever #40 clk32k = ~clk32k;
   end
   always @(posedge core_clk) cyc <= cyc + 1;

   // Short divider so one second is 64 time-base ticks and the run stays brief
   rtc_update_core #(.div_bits(6)) dut_u (.core_clk, .rst, .clk32k, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .irq_summary_flag);
   host_model host_u (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .hung());

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
      num_checks++;
      if (seen !== expected) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, expected, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // A stuck handshake ends the run
   always @(posedge host_u.hung) begin
      mismatches++;
      stop_test();
   end

   // Poll the pending bit until it reads the wanted level
   task automatic wait_pending(input logic lvl, input int limit);
      n = 0;
      do begin
         host_u.rd(idx_ctrl_a, d, r);
         n++;
      end while (d[7] !== lvl && n < limit);
      if (d[7] !== lvl) begin
         mismatches++;
         stop_test();
      end
   endtask

   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      for (i = 0; i < 7; i++) begin
         host_u.rd(set_idx[i], d, r);
         check("time reset", d, {24'h0, exp_val[i]});
      end
      host_u.rd(idx_ctrl_b, d, r);
      check("ctrl b reset", d, 32'h02);
      // Read-only control A and places off the map
      host_u.wr(idx_ctrl_a, 8'hff, r);
      host_u.rd(idx_ctrl_a, d, r);
      check("ctrl a", d, 32'h20);
      host_u.rd(8'h00, d, r);
      check("bad read", {30'h0, r}, {30'h0, resp_slverr});
      host_u.wr(8'h3f, 8'h55, r);
      check("bad write", {30'h0, r}, {30'h0, resp_slverr});
      // Hold updates while loading the time
      host_u.wr(idx_ctrl_b, 8'h82, r);
      for (i = 0; i < 7; i++) host_u.wr(set_idx[i], set_val[i], r);
      host_u.rd(idx_status_c, d, r);
      check("stale flags", d, 32'h0);
      host_u.wr(idx_ctrl_b, 8'h02, r);
      // One full second of time base before the first update
      wait_pending(1'b1, 2000);
      t_hi = cyc;
      host_u.rd(idx_seconds, d, r);
      check("sec before tick", d, 32'h59);
      wait_pending(1'b0, 200);
      check("pending width", {31'h0, (cyc - t_hi) inside {[130:170]}}, 32'h1);
      for (i = 0; i < 7; i++) begin
         host_u.rd(set_idx[i], d, r);
         check("rollover", d, {24'h0, exp_val[i]});
      end
      host_u.rd(idx_sec_alarm, d, r);
      check("alarm reg", d, 32'h0);
      check("irq gated", {31'h0, irq_summary_flag}, 32'h0);
      // Enabling over a flag already set raises the summary at once
      host_u.wr(idx_ctrl_b, 8'h22, r);
      @(posedge core_clk);
      check("irq on enable", {31'h0, irq_summary_flag}, 32'h1);
      host_u.rd(idx_status_c, d, r);
      check("status c", d, 32'hb0);
      check("irq cleared", {31'h0, irq_summary_flag}, 32'h0);
      host_u.rd(idx_status_c, d, r);
      check("status c again", d, 32'h0);
      host_u.wr(idx_ctrl_b, 8'ha2, r);
      host_u.rd(idx_ctrl_a, d, r);
      check("held pending", d, 32'h20);
      stop_test();
   end
endmodule

bind rtc_update_core rtc_update_monitor mon_u (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .irq_summary_flag);
